// file: inc/sec_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM command port
// Assumes: 25 MHz reference clock, 8-bit byte-wide EEPROM locations
// Notes:   Serial frame is start bit, 2-bit opcode, 8-bit address, 8 data bits
`default_nettype none
package sec_pkg;
	// ****************************************
	// Register map and field layout
	// ****************************************
	localparam logic [7:0] CMD_OFS    = 8'hB0;
	localparam logic [7:0] DATA_OFS   = 8'hB4;
	localparam int         ADDR_LSB   = 0;
	localparam int         LOADED_BIT = 8;
	localparam int         TOUT_BIT   = 9;
	localparam int         OP_LSB     = 28;
	localparam int         BUSY_BIT   = 31;
	localparam logic [7:0] ADDR_RST   = 8'h00;
	localparam logic [7:0] DATA_RST   = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ   = 25_000_000;
	localparam int TOUT_MS  = 30;
	localparam int TOUT_CYC = TOUT_MS * (CLK_HZ / 1000);
	localparam int HALF_CYC = 2;
	localparam int HDR_BITS = 11;
	localparam int FRM_BITS = 19;

	// ****************************************
	// Commands and states
	// ****************************************
	typedef enum logic [2:0] {
		OP_READ   = 3'h0,
		OP_EWDS   = 3'h1,
		OP_WREN   = 3'h2,
		OP_WRITE  = 3'h3,
		OP_WRFILL = 3'h4,
		OP_ERASE  = 3'h5,
		OP_ERFILL = 3'h6,
		OP_RELOAD = 3'h7
	} sec_op_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SHIFT = 2'h1,
		ST_GAP   = 2'h3,
		ST_WAIT  = 2'h2
	} sec_state_t;

	// Commands that program the array and must poll for ready
	function automatic logic is_prog(input sec_op_t op);
		return op == OP_WRITE || op == OP_WRFILL || op == OP_ERASE || op == OP_ERFILL;
	endfunction

	// Commands that clock a byte back from the EEPROM
	function automatic logic is_rd(input sec_op_t op);
		return op == OP_READ || op == OP_RELOAD;
	endfunction
endpackage
`default_nettype wire

// file: hw/sec_ctrl.sv
// Purpose: Command port that runs host commands against a serial EEPROM
// Assumes: Inputs synchronous to i_ref_clk, EEPROM data line shared in/out
// Notes:   Ready polling on the data line follows each programming command
`default_nettype none
`timescale 1ns/1ps
module sec_ctrl #(
	parameter int         TOUT_CYC = sec_pkg::TOUT_CYC,
	parameter int         TW       = 20,
	parameter logic [7:0] SIG      = 8'hA5 // Arbitrary reload signature
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic             o_rom_cs,
	output logic             o_rom_sclk,
	input  wire logic        i_rom_sdl,
	output logic             o_rom_sdl,
	output logic             o_rom_sdl_oe
);
	// ****************************************
	// State
	// ****************************************
	sec_pkg::sec_state_t state_q, state_d;
	sec_pkg::sec_op_t    op_q;
	logic [7:0]          addr_q;
	logic [7:0]          data_q;
	logic [7:0]          rd_q;
	logic [18:0]         sh_q;
	logic [4:0]          bit_q;
	logic [2:0]          ph_q;
	logic [TW-1:0]       tcnt_q;
	logic                tout_q;
	logic                loaded_q;
	logic                boot_q;
	logic [31:0]         rdata_q;

	// ****************************************
	// Decode
	// ****************************************
	// Host strobes and command start
	wire idle     = state_q == sec_pkg::ST_IDLE;
	wire busy     = !idle;
	wire cmd_wr   = i_wr && i_addr == sec_pkg::CMD_OFS;
	wire data_wr  = i_wr && i_addr == sec_pkg::DATA_OFS && idle;
	wire boot_go  = boot_q && idle;
	wire cmd_go   = cmd_wr && i_wdata[sec_pkg::BUSY_BIT] && idle && !boot_q;
	wire go       = boot_go || cmd_go;
	wire sec_pkg::sec_op_t go_op = boot_go ? sec_pkg::OP_RELOAD :
		sec_pkg::sec_op_t'(i_wdata[sec_pkg::OP_LSB +: 3]);
	wire [7:0] go_addr = boot_go ? 8'h00 : i_wdata[7:0];

	// Bit timing: one bit is two half periods of the serial clock
	wire ph_end   = ph_q == 3'(2 * sec_pkg::HALF_CYC - 1);
	wire ph_smp   = ph_q == 3'(sec_pkg::HALF_CYC);
	wire [4:0] n_bits = (op_q == sec_pkg::OP_WREN || op_q == sec_pkg::OP_EWDS ||
		op_q == sec_pkg::OP_ERASE || op_q == sec_pkg::OP_ERFILL) ?
		5'(sec_pkg::HDR_BITS) : 5'(sec_pkg::FRM_BITS);
	wire last_bit = bit_q == n_bits - 5'h01;
	wire in_data  = bit_q >= 5'(sec_pkg::HDR_BITS);
	wire frm_end  = state_q == sec_pkg::ST_SHIFT && ph_end && last_bit;
	wire rd_done  = frm_end && sec_pkg::is_rd(op_q);
	wire load_ok  = rd_done && op_q == sec_pkg::OP_RELOAD && rd_q == SIG;

	// Ready polling; line high means ready, also with no EEPROM fitted
	wire in_wait  = state_q == sec_pkg::ST_WAIT;
	wire rdy      = in_wait && i_rom_sdl;
	wire tout_hit = in_wait && !i_rom_sdl && tcnt_q == TW'(TOUT_CYC - 1);

	// Software write-one-to-clear of the sticky flags
	wire clr_tout = cmd_wr && i_wdata[sec_pkg::TOUT_BIT];
	wire clr_load = cmd_wr && i_wdata[sec_pkg::LOADED_BIT];

	// ****************************************
	// Frame builder
	// ****************************************
	// Opcode and address bits per command; opcode-00 commands use address bits as
	// sub-opcode. Enable must precede programming or the EEPROM refuses it.
	function automatic logic [18:0] frame(input sec_pkg::sec_op_t op,
		input logic [7:0] a, input logic [7:0] d);
		logic [1:0] oc;
		logic [7:0] fa;
		oc = 2'h0;
		fa = a;
		case (op)
			sec_pkg::OP_READ:   oc = 2'h2;
			sec_pkg::OP_RELOAD: begin
				oc = 2'h2;
				fa = 8'h00;
			end
			sec_pkg::OP_WRITE:  oc = 2'h1;
			sec_pkg::OP_ERASE:  oc = 2'h3;
			sec_pkg::OP_WREN:   fa = 8'hC0;
			sec_pkg::OP_EWDS:   fa = 8'h00;
			sec_pkg::OP_WRFILL: fa = 8'h40;
			sec_pkg::OP_ERFILL: fa = 8'h80;
			default:            oc = 2'h0;
		endcase
		return {1'b1, oc, fa, d};
	endfunction

	// ****************************************
	// Sequencer
	// ****************************************
	// Next state; only programming commands reach the polling states
	always_comb begin
		state_d = state_q;
		case (state_q)
			sec_pkg::ST_IDLE:  if (go) state_d = sec_pkg::ST_SHIFT;
			sec_pkg::ST_SHIFT: begin
				if (frm_end) state_d = sec_pkg::is_prog(op_q) ? sec_pkg::ST_GAP :
					sec_pkg::ST_IDLE;
			end
			sec_pkg::ST_GAP:   if (ph_end) state_d = sec_pkg::ST_WAIT;
			sec_pkg::ST_WAIT:  if (rdy || tout_hit) state_d = sec_pkg::ST_IDLE;
			default:           state_d = sec_pkg::ST_IDLE;
		endcase
	end

	// State, phase and bit counters
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_q <= sec_pkg::ST_IDLE;
			ph_q    <= 3'h0;
			bit_q   <= 5'h00;
		end else begin
			state_q <= state_d;
			ph_q    <= (idle || in_wait || ph_end) ? 3'h0 : ph_q + 3'h1;
			bit_q   <= go ? 5'h00 : (state_q == sec_pkg::ST_SHIFT && ph_end) ?
				bit_q + 5'h01 : bit_q;
		end
	end

	// Shift register out and read byte in
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			sh_q <= 19'h00000;
			rd_q <= 8'h00;
		end else begin
			if (go) sh_q <= frame(go_op, go_addr, data_q);
			else if (state_q == sec_pkg::ST_SHIFT && ph_end) sh_q <= {sh_q[17:0], 1'b0};
			if (state_q == sec_pkg::ST_SHIFT && ph_smp && in_data)
				rd_q <= {rd_q[6:0], i_rom_sdl};
		end
	end

	// Time-out counter; counts only while polling for ready
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) tcnt_q <= '0;
		else tcnt_q <= in_wait ? tcnt_q + TW'(1) : '0;
	end

	// ****************************************
	// Registers
	// ****************************************
	// Command fields latched only when idle, so a running command is never disturbed
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			op_q   <= sec_pkg::OP_READ;
			addr_q <= sec_pkg::ADDR_RST;
			boot_q <= 1'b1;
		end else begin
			if (go) op_q <= go_op;
			if (cmd_wr && idle) addr_q <= i_wdata[7:0];
			if (boot_go) boot_q <= 1'b0;
		end
	end

	// Data byte from host or from a finished READ; a RELOAD leaves it unchanged
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) data_q <= sec_pkg::DATA_RST;
		else if (rd_done && op_q == sec_pkg::OP_READ) data_q <= rd_q;
		else if (data_wr) data_q <= i_wdata[7:0];
	end

	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			tout_q   <= 1'b0;
			loaded_q <= 1'b0;
		end else begin
			tout_q   <= tout_hit || (tout_q && !clr_tout && !cmd_go);
			loaded_q <= load_ok || (loaded_q && !clr_load);
		end
	end

	// Read data stands only in the cycle after the strobe
	wire [31:0] cmd_view = {busy, op_q, 18'h00000, tout_q, loaded_q, addr_q};
	wire [31:0] rd_mux = (i_addr == sec_pkg::CMD_OFS) ? cmd_view :
		(i_addr == sec_pkg::DATA_OFS) ? {24'h000000, data_q} : 32'h00000000;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) rdata_q <= 32'h00000000;
		else rdata_q <= i_rd ? rd_mux : 32'h00000000;
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Select drops for one bit time between frame and ready polling
	assign o_rdata      = rdata_q;
	assign o_rom_cs     = state_q == sec_pkg::ST_SHIFT || in_wait;
	assign o_rom_sclk   = state_q == sec_pkg::ST_SHIFT && ph_q >= 3'(sec_pkg::HALF_CYC);
	assign o_rom_sdl    = sh_q[18];
	assign o_rom_sdl_oe = state_q == sec_pkg::ST_SHIFT && !(sec_pkg::is_rd(op_q) && in_data);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_prog_go;
		cmd_go && sec_pkg::is_prog(go_op);
	endsequence
	sequence s_tout;
		tout_hit;
	endsequence

	tout_idle_a: assert property (s_tout |=> idle && !busy)
		else $error("time-out did not return to idle");
	tout_count_a: assert property (tout_hit |-> tcnt_q == TW'(TOUT_CYC - 1) && $past(in_wait))
		else $error("time-out fired at wrong count");
	tout_flag_a: assert property (s_tout ##1 !(clr_tout || cmd_go)[*2] |=> tout_q)
		else $error("time-out flag not held");
	high_done_a: assert property (in_wait && i_rom_sdl |=> idle)
		else $error("busy held with data line high");
	wait_prog_a: assert property (in_wait |-> sec_pkg::is_prog(op_q))
		else $error("non-programming command polling");
	load_set_a: assert property (load_ok |=> loaded_q ##1 (loaded_q || $past(clr_load)))
		else $error("loaded flag not set");
	addr_hold_a: assert property (busy && !$rose(busy) |-> $stable(addr_q))
		else $error("address changed while busy");
	data_rsv_a: assert property (i_rd && i_addr == sec_pkg::DATA_OFS |=> o_rdata[31:8] == 24'h0)
		else $error("data reserved bits nonzero");
	prog_frame_a: assert property (s_prog_go |=> sh_q[18] && ($past(go_op) == sec_pkg::OP_ERASE ||
		$past(go_op) == sec_pkg::OP_ERFILL || sh_q[7:0] == $past(data_q)))
		else $error("programming frame wrong");
	busy_ign_a: assert property (busy && cmd_wr |=> $stable(op_q))
		else $error("command taken while busy");
endmodule // sec_ctrl
`default_nettype wire

// file: bench/sec_rom_model.sv
// Purpose: Behavioural serial EEPROM on the far side of the command port
// Assumes: Frame is start bit, 2-bit opcode, 8-bit address, 8 data bits
// Notes:   Ready answers at once; an absent part leaves the line alone
`timescale 1ns/1ps
`default_nettype none
module sec_rom_model (
	input  wire logic i_cs,
	input  wire logic i_sclk,
	input  wire logic i_sdl,
	input  wire logic i_present,
	output logic      o_sdl,
	output logic      o_oe
);
	logic [7:0]  mem [256];
	logic [17:0] sh;
	logic [7:0]  ra;
	logic        en, prg, poll, rdop;
	int          n;
	initial begin
		mem = '{default: 8'hFF};
		mem[0] = 8'hA5;
		{en, prg, poll, rdop, n, ra} = '0;
	end
	// Shift in on each rising serial clock; deselect restarts the frame
	always @(posedge i_sclk or negedge i_cs) begin
		if (!i_cs) begin
			n = 0;
			rdop = 1'b0;
		end else if (i_present) begin
			sh = {sh[16:0], i_sdl};
			n = n + 1;
			if (n == 11) begin
				ra = sh[7:0];
				rdop = sh[9:8] == 2'b10;
				if (sh[9:8] == 2'b00 && sh[7:6] == 2'b11) en = 1'b1;
				if (sh[9:8] == 2'b00 && sh[7:6] == 2'b00) en = 1'b0;
				if (en && sh[9:8] == 2'b11) mem[sh[7:0]] = 8'hFF;
				if (en && sh[9:8] == 2'b00 && sh[7:6] == 2'b10) mem = '{default: 8'hFF};
				prg = sh[9:8] == 2'b11 || (sh[9:8] == 2'b00 && sh[7:6] == 2'b10);
			end
			if (n == 19) begin
				if (en && sh[17:16] == 2'b01) mem[sh[15:8]] = sh[7:0];
				if (en && sh[17:16] == 2'b00) mem = '{default: sh[7:0]};
				prg = sh[17:16] != 2'b10;
			end
		end
	end
	// Next select after a programming frame is the ready poll
	always @(posedge i_cs) begin
		poll = prg;
		prg = 1'b0;
	end
	// Count has already stepped when the controller samples, so bit 7 stands at count 12
	assign o_oe  = i_present && i_cs && ((poll && n == 0) || (rdop && n >= 12 && n <= 19));
	assign o_sdl = (poll && n == 0) ? 1'b1 : mem[ra][3'(19 - n)];
endmodule // sec_rom_model
`default_nettype wire

// file: bench/tb_serial_eeprom_command_port.sv
// Purpose: Self-checking bench for the EEPROM command port
// Assumes: Time-out shortened to TO cycles
// Notes:   Mirror array predicts every read-back
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_command_port;
	localparam int TO = 50;
	logic        i_ref_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
	logic        pull = 1, present = 1, en = 0, ld = 1;
	logic [7:0]  i_addr = 0, a, mm [256];
	logic [31:0] i_wdata = 0, o_rdata, got;
	logic        cs, sclk, d_sdl, d_oe, m_sdl, m_oe;
	int          n_mismatch = 0, compares = 0, cyc = 0, seed = 32'hdeca9e40;
	sec_pkg::sec_op_t tbl [9] = '{sec_pkg::OP_WRITE, sec_pkg::OP_WREN, sec_pkg::OP_WRITE,
		sec_pkg::OP_ERASE, sec_pkg::OP_WRFILL, sec_pkg::OP_ERFILL, sec_pkg::OP_RELOAD,
		sec_pkg::OP_EWDS, sec_pkg::OP_WRITE};
	// Released line falls to the pull level
	wire logic line = d_oe ? d_sdl : (m_oe ? m_sdl : pull);

	sec_ctrl #(.TOUT_CYC(TO)) i_sec_ctrl (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_rom_cs(cs), .o_rom_sclk(sclk), .i_rom_sdl(line), .o_rom_sdl(d_sdl),
		.o_rom_sdl_oe(d_oe));
	sec_rom_model i_sec_rom_model (.i_cs(cs), .i_sclk(sclk), .i_sdl(line),
		.i_present(present), .o_sdl(m_sdl), .o_oe(m_oe));

	// **************************************
	// Clock, watchdog and bus tasks
	// **************************************
	always #20 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Each access ends with an idle edge so strobes never meet
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		i_addr <= ad;
		i_wdata <= dt;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	task automatic rd(input logic [7:0] ad);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(posedge i_ref_clk);
		got = o_rdata;
	endtask
	task automatic waitidle();
		rd(8'hB0);
		for (int i = 0; i < 300 && got[31] !== 1'b0; i++) rd(8'hB0);
	endtask
	task automatic op(input sec_pkg::sec_op_t c, input logic [7:0] ad, input logic [7:0] dt,
		input logic to);
		int t;
		wr(8'hB4, {24'h0, dt});
		t = cyc;
		wr(8'hB0, {1'b1, c, 20'h0, ad});
		rd(8'hB0);
		chk(got[31], 32'h1);
		wr(8'hB0, {1'b1, sec_pkg::OP_WRITE, 20'h0, ~ad});
		waitidle();
		t = cyc - t;
		if (present && c == sec_pkg::OP_WREN) en = 1'b1;
		if (present && c == sec_pkg::OP_EWDS) en = 1'b0;
		if (present && en && c == sec_pkg::OP_WRITE) mm[ad] = dt;
		if (present && en && c == sec_pkg::OP_ERASE) mm[ad] = 8'hFF;
		if (present && en && c == sec_pkg::OP_WRFILL) mm = '{default: dt};
		if (present && en && c == sec_pkg::OP_ERFILL) mm = '{default: 8'hFF};
		if (c == sec_pkg::OP_RELOAD) ld = present && mm[0] == 8'hA5;
		chk(got[9:0], {to, ld, ad});
		if (to) chk(t > TO + 78 && t < TO + 92, 32'h1);
	endtask
	task automatic results();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// **************************************
	// Main sequence
	// **************************************
	initial begin
		mm = '{default: 8'hFF};
		mm[0] = 8'hA5;
		got = '1;
		repeat (5) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rd(8'hB4);
		chk(got, 32'h0);
		waitidle();
		chk(got[9:0], 10'h100);
		wr(8'hB0, 32'h100);
		ld = 1'b0;
		rd(8'hB0);
		chk(got[9:0], 10'h0);
		got = $random(seed);
		wr(8'hB4, got);
		rd(8'hB4);
		chk(got, {24'h0, i_wdata[7:0]});
		rd(8'h10);
		chk(got, 32'h0);
		foreach (tbl[i]) begin
			got = $random(seed);
			a = got[7:0];
			op(tbl[i], a, got[15:8], 1'b0);
			for (int k = 0; k < 2; k++) begin
				op(sec_pkg::OP_READ, a + 8'(k), got[23:16], 1'b0);
				rd(8'hB4);
				chk(got, {24'h0, mm[a + 8'(k)]});
			end
		end
		present <= 1'b0;
		pull <= 1'b0;
		op(sec_pkg::OP_WRITE, a, 8'h5A, 1'b1);
		op(sec_pkg::OP_READ, a, 8'h5A, 1'b0);
		pull <= 1'b1;
		op(sec_pkg::OP_ERASE, a, 8'h5A, 1'b0);
		present <= 1'b1;
		op(sec_pkg::OP_WREN, 8'h00, 8'h00, 1'b0);
		op(sec_pkg::OP_WRITE, 8'h00, 8'hA5, 1'b0);
		op(sec_pkg::OP_RELOAD, 8'h00, 8'h00, 1'b0);
		results();
	end
endmodule // tb_serial_eeprom_command_port
`default_nettype wire
